// File: hw/cct_edge_det.v
`timescale 1ns/1ps
`default_nettype none
module cct_edge_det (
  input  wire clk,
  input  wire reset,
  input  wire pin,
  input  wire rising_sel,
  output wire edge_hit
);
  reg prev_ff;

  // Rising when selected high, falling otherwise
  assign edge_hit = rising_sel ? (pin & ~prev_ff) : (~pin & prev_ff);

  // Reload from the pin so a steady level never looks like an edge
  always @(posedge clk) begin
    if (reset) begin
      prev_ff <= pin;
    end else begin
      prev_ff <= pin;
    end
  end
endmodule
`default_nettype wire

// File: hw/cct_prescaler.v
`timescale 1ns/1ps
`default_nettype none
module cct_prescaler #(
  parameter DIV = 4
) (
  input  wire clk,
  input  wire reset,
  input  wire run,
  output wire tick
);
  localparam W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam integer LAST_I = DIV - 1;
  localparam [W-1:0] LAST = LAST_I[W-1:0];

  reg  [W-1:0] div_ff;
  wire [W-1:0] nxt_div;

  assign tick    = run && (div_ff == LAST);
  assign nxt_div = tick ? {W{1'b0}} : div_ff + {{(W-1){1'b0}}, 1'b1};

  always @(posedge clk) begin
    if (reset) begin
      div_ff <= {W{1'b0}};
    end else if (run) begin
      div_ff <= nxt_div;
    end
  end
endmodule
`default_nettype wire

// File: hw/cct_timer.v
// How it works
// - Capture interrupt enable bit, cleared by reset
// - Compare interrupt enable bit, cleared by reset
// - Overflow interrupt enable bit, cleared by reset
// - Edge select picks capture polarity, reset-proof
// - Compare match drives output pin to level bit
// - Capture flag: set on edge, status-then-low clears
// - Compare flag sets on counter equal compare
// - Overflow flag on wrap, status-then-counter-low clears
// - Counter high read freezes low byte; writes ignored
// - Alt pair latches likewise, never clears overflow
// - Edge copies counter; high read blocks capture
// - Compare high write suspends matching until low
// - Compare low access after status clears flag
// - Timer runs during wait; interrupt wakes CPU
// - Stop halts counter; reset exit loads fffc
// - Stop edge arms; delivered on interrupt exit
// - Free-running 16-bit counter, reads never disturb
// - Counter advances every fourth clock
// - Compare evaluated once every fourth clock
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cct_consts.vh"
module cct_timer #(
  parameter PRESCALE = `CCT_PRESCALE
) (
  input  wire       clk,
  input  wire       reset,
  input  wire       por,
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_en,
  input  wire       rd_en,
  output reg  [7:0] rdata_ff,
  input  wire       stop_mode,
  input  wire       capture_input_pin,
  output reg        compare_output_pin_ff,
  output reg        timer_irq_ff
);
  reg  [15:0] cnt_ff;
  reg  [15:0] capture_ff;
  reg  [15:0] compare_ff;
  reg         capture_irq_enable_ff;
  reg         compare_irq_enable_ff;
  reg         overflow_irq_enable_ff;
  reg         capture_edge_select_ff;
  reg         compare_output_level_ff;
  reg         capture_flag_ff;
  reg         compare_flag_ff;
  reg         overflow_flag_ff;
  reg         capture_arm_ff;
  reg         compare_arm_ff;
  reg         overflow_arm_ff;
  reg         cnt_lat_ff;
  reg  [7:0]  cnt_lat_val_ff;
  reg         alt_lat_ff;
  reg  [7:0]  alt_lat_val_ff;
  reg         capture_block_ff;
  reg         compare_hold_ff;
  reg         stop_pend_ff;
  reg  [15:0] stop_pend_val_ff;
  reg         stop_prev_ff;
  reg  [7:0]  nxt_rdata;

  wire        any_reset;
  wire        tick;
  wire        edge_hit;
  wire        stop_exit;
  wire        rd_status;
  wire        rd_cap_hi;
  wire        rd_cap_lo;
  wire        rd_cnt_hi;
  wire        rd_cnt_lo;
  wire        rd_alt_hi;
  wire        rd_alt_lo;
  wire        wr_ctl;
  wire        wr_cmp_hi;
  wire        wr_cmp_lo;
  wire        acc_cmp_lo;
  wire        run_capture;
  wire        pend_deliver;
  wire        capture_set;
  wire        compare_set;
  wire        overflow_set;
  wire [15:0] capture_src;

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    input       strobe;
    begin
      hit = strobe && (a == ofs);
    end
  endfunction

  assign any_reset = reset | por;
  assign rd_status = hit(addr, `CCT_OFS_STATUS, rd_en);
  assign rd_cap_hi = hit(addr, `CCT_OFS_CAPTURE_HIGH, rd_en);
  assign rd_cap_lo = hit(addr, `CCT_OFS_CAPTURE_LOW, rd_en);
  assign rd_cnt_hi = hit(addr, `CCT_OFS_COUNTER_HIGH, rd_en);
  assign rd_cnt_lo = hit(addr, `CCT_OFS_COUNTER_LOW, rd_en);
  assign rd_alt_hi = hit(addr, `CCT_OFS_ALT_HIGH, rd_en);
  assign rd_alt_lo = hit(addr, `CCT_OFS_ALT_LOW, rd_en);
  assign wr_ctl    = hit(addr, `CCT_OFS_CONTROL, wr_en);
  assign wr_cmp_hi = hit(addr, `CCT_OFS_COMPARE_HIGH, wr_en);
  assign wr_cmp_lo = hit(addr, `CCT_OFS_COMPARE_LOW, wr_en);
  assign acc_cmp_lo = wr_cmp_lo |
                      hit(addr, `CCT_OFS_COMPARE_LOW, rd_en);

  // Counter and prescaler freeze in stop mode
  cct_prescaler #(
    .DIV (PRESCALE)
  ) u_prescaler (
    .clk   (clk),
    .reset (any_reset),
    .run   (~stop_mode),
    .tick  (tick)
  );

  cct_edge_det u_edge (
    .clk        (clk),
    .reset      (any_reset),
    .pin        (capture_input_pin),
    .rising_sel (capture_edge_select_ff),
    .edge_hit   (edge_hit)
  );

  // Leaving stop without reset counts as an interrupt exit
  assign stop_exit    = stop_prev_ff & ~stop_mode;
  assign pend_deliver = stop_exit & stop_pend_ff;
  assign run_capture  = (edge_hit & ~stop_mode) | pend_deliver;
  assign capture_src  = pend_deliver ? stop_pend_val_ff : cnt_ff;
  // A blocked capture also leaves the flag alone
  assign capture_set  = run_capture & ~capture_block_ff;
  assign compare_set  = tick & ~compare_hold_ff &
                        (cnt_ff == compare_ff);
  assign overflow_set = tick & (cnt_ff == `CCT_CNT_MAX);

  // Free-running counter; register reads never touch it
  always @(posedge clk) begin
    if (any_reset) begin
      cnt_ff <= `CCT_CNT_STOP_RESET;
    end else if (tick) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // Control register
  always @(posedge clk) begin
    if (any_reset) begin
      capture_irq_enable_ff   <= 1'b0;
      compare_irq_enable_ff   <= 1'b0;
      overflow_irq_enable_ff  <= 1'b0;
      compare_output_level_ff <= 1'b0;
    end else if (wr_ctl) begin
      capture_irq_enable_ff   <= wdata[`CCT_CTL_CAPTURE_IE];
      compare_irq_enable_ff   <= wdata[`CCT_CTL_COMPARE_IE];
      overflow_irq_enable_ff  <= wdata[`CCT_CTL_OVERFLOW_IE];
      compare_output_level_ff <= wdata[`CCT_CTL_OUT_LEVEL];
    end
  end

  // Edge select survives the ordinary reset, only power-on clears it
  always @(posedge clk) begin
    if (por) begin
      capture_edge_select_ff <= 1'b0;
    end else if (wr_ctl) begin
      capture_edge_select_ff <= wdata[`CCT_CTL_EDGE_SEL];
    end
  end

  // Flags: untouched by reset; a set beats a clear in the same cycle
  always @(posedge clk) begin
    if (por) begin
      capture_flag_ff  <= 1'b0;
      compare_flag_ff  <= 1'b0;
      overflow_flag_ff <= 1'b0;
    end else begin
      if (capture_set) begin
        capture_flag_ff <= 1'b1;
      end else if (rd_cap_lo && capture_arm_ff) begin
        capture_flag_ff <= 1'b0;
      end
      if (compare_set) begin
        compare_flag_ff <= 1'b1;
      end else if (acc_cmp_lo && compare_arm_ff) begin
        compare_flag_ff <= 1'b0;
      end
      if (overflow_set) begin
        overflow_flag_ff <= 1'b1;
      end else if (rd_cnt_lo && overflow_arm_ff) begin
        overflow_flag_ff <= 1'b0;
      end
    end
  end

  // Clear sequence: a status read arms only the flags then set
  always @(posedge clk) begin
    if (any_reset) begin
      capture_arm_ff  <= 1'b0;
      compare_arm_ff  <= 1'b0;
      overflow_arm_ff <= 1'b0;
    end else begin
      if (rd_status && capture_flag_ff) begin
        capture_arm_ff <= 1'b1;
      end else if (rd_cap_lo) begin
        capture_arm_ff <= 1'b0;
      end
      if (rd_status && compare_flag_ff) begin
        compare_arm_ff <= 1'b1;
      end else if (acc_cmp_lo) begin
        compare_arm_ff <= 1'b0;
      end
      if (rd_status && overflow_flag_ff) begin
        overflow_arm_ff <= 1'b1;
      end else if (rd_cnt_lo) begin
        overflow_arm_ff <= 1'b0;
      end
    end
  end

  // Coherent 16-bit reads of both counter pairs
  always @(posedge clk) begin
    if (any_reset) begin
      cnt_lat_ff     <= 1'b0;
      cnt_lat_val_ff <= 8'h00;
      alt_lat_ff     <= 1'b0;
      alt_lat_val_ff <= 8'h00;
    end else begin
      if (rd_cnt_hi) begin
        cnt_lat_ff     <= 1'b1;
        cnt_lat_val_ff <= cnt_ff[7:0];
      end else if (rd_cnt_lo) begin
        cnt_lat_ff <= 1'b0;
      end
      if (rd_alt_hi) begin
        alt_lat_ff     <= 1'b1;
        alt_lat_val_ff <= cnt_ff[7:0];
      end else if (rd_alt_lo) begin
        alt_lat_ff <= 1'b0;
      end
    end
  end

  // Capture registers and the high-read block
  always @(posedge clk) begin
    if (any_reset) begin
      capture_block_ff <= 1'b0;
    end else if (rd_cap_hi) begin
      capture_block_ff <= 1'b1;
    end else if (rd_cap_lo) begin
      capture_block_ff <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (por) begin
      capture_ff <= 16'h0000;
    end else if (capture_set) begin
      capture_ff <= capture_src;
    end
  end

  // Edges seen in stop are parked until the stop is left
  always @(posedge clk) begin
    if (any_reset) begin
      stop_pend_ff     <= 1'b0;
      stop_pend_val_ff <= 16'h0000;
      stop_prev_ff     <= 1'b0;
    end else begin
      stop_prev_ff <= stop_mode;
      if (stop_mode && edge_hit && !stop_pend_ff) begin
        stop_pend_ff     <= 1'b1;
        stop_pend_val_ff <= cnt_ff;
      end else if (stop_exit) begin
        stop_pend_ff <= 1'b0;
      end
    end
  end

  // Compare register; high write holds matching until low write
  always @(posedge clk) begin
    if (any_reset) begin
      compare_hold_ff <= 1'b0;
    end else if (wr_cmp_hi) begin
      compare_hold_ff <= 1'b1;
    end else if (wr_cmp_lo) begin
      compare_hold_ff <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (por) begin
      compare_ff <= 16'hffff;
    end else begin
      if (wr_cmp_hi) begin
        compare_ff[15:8] <= wdata;
      end
      if (wr_cmp_lo) begin
        compare_ff[7:0] <= wdata;
      end
    end
  end

  // Output pin moves only on a real match or a reset
  always @(posedge clk) begin
    if (any_reset) begin
      compare_output_pin_ff <= 1'b0;
    end else if (compare_set) begin
      compare_output_pin_ff <= compare_output_level_ff;
    end
  end

  // Level request; also the wake source out of wait
  always @(posedge clk) begin
    if (any_reset) begin
      timer_irq_ff <= 1'b0;
    end else begin
      timer_irq_ff <= (capture_flag_ff & capture_irq_enable_ff) |
                      (compare_flag_ff & compare_irq_enable_ff) |
                      (overflow_flag_ff & overflow_irq_enable_ff);
    end
  end

  // Read mux; writes to read-only pairs fall through unused
  always @* begin
    nxt_rdata = 8'h00;
    case (addr)
      `CCT_OFS_CONTROL: begin
        nxt_rdata[`CCT_CTL_CAPTURE_IE]  = capture_irq_enable_ff;
        nxt_rdata[`CCT_CTL_COMPARE_IE]  = compare_irq_enable_ff;
        nxt_rdata[`CCT_CTL_OVERFLOW_IE] = overflow_irq_enable_ff;
        nxt_rdata[`CCT_CTL_EDGE_SEL]    = capture_edge_select_ff;
        nxt_rdata[`CCT_CTL_OUT_LEVEL]   = compare_output_level_ff;
      end
      `CCT_OFS_STATUS: begin
        nxt_rdata[`CCT_STS_CAPTURE_FLAG]  = capture_flag_ff;
        nxt_rdata[`CCT_STS_COMPARE_FLAG]  = compare_flag_ff;
        nxt_rdata[`CCT_STS_OVERFLOW_FLAG] = overflow_flag_ff;
      end
      `CCT_OFS_CAPTURE_HIGH: begin
        nxt_rdata = capture_ff[15:8];
      end
      `CCT_OFS_CAPTURE_LOW: begin
        nxt_rdata = capture_ff[7:0];
      end
      `CCT_OFS_COMPARE_HIGH: begin
        nxt_rdata = compare_ff[15:8];
      end
      `CCT_OFS_COMPARE_LOW: begin
        nxt_rdata = compare_ff[7:0];
      end
      `CCT_OFS_COUNTER_HIGH: begin
        nxt_rdata = cnt_ff[15:8];
      end
      `CCT_OFS_COUNTER_LOW: begin
        nxt_rdata = cnt_lat_ff ? cnt_lat_val_ff : cnt_ff[7:0];
      end
      `CCT_OFS_ALT_HIGH: begin
        nxt_rdata = cnt_ff[15:8];
      end
      `CCT_OFS_ALT_LOW: begin
        nxt_rdata = alt_lat_ff ? alt_lat_val_ff : cnt_ff[7:0];
      end
      default: begin
        nxt_rdata = 8'h00;
      end
    endcase
  end

  // Data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (any_reset) begin
      rdata_ff <= 8'h00;
    end else if (rd_en) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// File: shared/cct_consts.vh
`ifndef CCT_CONSTS_VH
`define CCT_CONSTS_VH

// Register byte addresses on the plain register port
`define CCT_ADDR_W            8
`define CCT_OFS_CONTROL       8'h12
`define CCT_OFS_STATUS        8'h13
`define CCT_OFS_CAPTURE_HIGH  8'h14
`define CCT_OFS_CAPTURE_LOW   8'h15
`define CCT_OFS_COMPARE_HIGH  8'h16
`define CCT_OFS_COMPARE_LOW   8'h17
`define CCT_OFS_COUNTER_HIGH  8'h18
`define CCT_OFS_COUNTER_LOW   8'h19
`define CCT_OFS_ALT_HIGH      8'h1a
`define CCT_OFS_ALT_LOW       8'h1b

// Control register bit positions
`define CCT_CTL_CAPTURE_IE    7
`define CCT_CTL_COMPARE_IE    6
`define CCT_CTL_OVERFLOW_IE   5
`define CCT_CTL_EDGE_SEL      1
`define CCT_CTL_OUT_LEVEL     0

// Status register bit positions
`define CCT_STS_CAPTURE_FLAG  7
`define CCT_STS_COMPARE_FLAG  6
`define CCT_STS_OVERFLOW_FLAG 5

// Counter values and timing
`define CCT_CNT_STOP_RESET    16'hfffc
`define CCT_CNT_MAX           16'hffff
`define CCT_PRESCALE          4

`endif

// File: tb/cct_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "cct_consts.vh"
module cct_cpu_model (
  input  wire logic       clk,
  input  wire logic [7:0] rdata_ff,
  output var  logic [7:0] addr,
  output var  logic [7:0] wdata,
  output var  logic       wr_en,
  output var  logic       rd_en
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    d = rdata_ff;
  endtask

  // No interrupt masking here; the caller keeps irq off around it
  task automatic cmp_set(input logic [7:0] hi, input logic [7:0] lo);
    logic [7:0] s;
    wr(`CCT_OFS_COMPARE_HIGH, hi);
    rd(`CCT_OFS_STATUS, s);
    wr(`CCT_OFS_COMPARE_LOW, lo);
  endtask
endmodule
`default_nettype wire

// File: tb/cct_timer_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "cct_consts.vh"
module cct_timer_props #(
  parameter PRESCALE = 4
) (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       por,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rdata_ff,
  input wire logic       stop_mode,
  input wire logic       capture_input_pin,
  input wire logic       compare_output_pin_ff,
  input wire logic       timer_irq_ff
);
  // Mirror of enables, edge select and level; edge select survives reset
  logic [4:0] ctl_ff;
  always_ff @(posedge clk) begin
    if (por) begin
      ctl_ff <= 5'h00;
    end else if (reset) begin
      ctl_ff <= ctl_ff & 5'h02;
    end else if (wr_en && addr == `CCT_OFS_CONTROL) begin
      ctl_ff <= {wdata[7:5], wdata[1:0]};
    end
  end

  property p_ctl_readback;
    @(posedge clk) disable iff (reset || por)
    rd_en && addr == `CCT_OFS_CONTROL |=> (rdata_ff & 8'he3) ==
      {$past(ctl_ff[4:2]), 3'h0, $past(ctl_ff[1:0])};
  endproperty
  a_ctl_readback: assert property (p_ctl_readback)
    else $error("control readback wrong");

  property p_sts_spare;
    @(posedge clk) disable iff (reset || por)
    rd_en && addr == `CCT_OFS_STATUS |=> rdata_ff[4:0] == 5'h00;
  endproperty
  a_sts_spare: assert property (p_sts_spare)
    else $error("status spare bits set");

  property p_rd_idle;
    @(posedge clk) disable iff (reset || por)
    !rd_en |=> rdata_ff == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");

  property p_pin_level;
    @(posedge clk) disable iff (reset || por)
    $changed(compare_output_pin_ff) && !$past(reset) && !$past(por) |->
      compare_output_pin_ff == $past(ctl_ff[0]);
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("compare pin differs from level");

  property p_irq_gate;
    @(posedge clk) disable iff (reset || por)
    $past(ctl_ff[4:2]) == 3'h0 |-> !timer_irq_ff;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq with all enables off");

  property p_irq_status;
    @(posedge clk) disable iff (reset || por)
    rd_en && addr == `CCT_OFS_STATUS |=>
      timer_irq_ff == (|(rdata_ff[7:5] & $past(ctl_ff[4:2])));
  endproperty
  a_irq_status: assert property (p_irq_status)
    else $error("irq disagrees with flags");

  // Four stopped samples so a tick already in flight may land first
  property p_stop_hold;
    @(posedge clk) disable iff (reset || por)
    stop_mode && $past(stop_mode) && $past(stop_mode, 2) &&
      $past(stop_mode, 3) && !$past(reset) && !$past(por) |->
      $stable(compare_output_pin_ff);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("compare pin moved in stop");

  property p_reset_quiet;
    @(posedge clk) disable iff (por)
    reset |=> !compare_output_pin_ff && !timer_irq_ff;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
endmodule

bind cct_timer cct_timer_props #(.PRESCALE(PRESCALE)) cct_timer_props_i (
  .clk                   (clk),
  .reset                 (reset),
  .por                   (por),
  .addr                  (addr),
  .wdata                 (wdata),
  .wr_en                 (wr_en),
  .rd_en                 (rd_en),
  .rdata_ff              (rdata_ff),
  .stop_mode             (stop_mode),
  .capture_input_pin     (capture_input_pin),
  .compare_output_pin_ff (compare_output_pin_ff),
  .timer_irq_ff          (timer_irq_ff)
);
`default_nettype wire

// File: tb/cct_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cct_consts.vh"
module cct_timer_tb;
  localparam logic [7:0] a_ctl  = `CCT_OFS_CONTROL;
  localparam logic [7:0] a_sts  = `CCT_OFS_STATUS;
  localparam logic [7:0] a_caph = `CCT_OFS_CAPTURE_HIGH;
  localparam logic [7:0] a_capl = `CCT_OFS_CAPTURE_LOW;
  localparam logic [7:0] a_cmpl = `CCT_OFS_COMPARE_LOW;
  localparam logic [7:0] a_cnth = `CCT_OFS_COUNTER_HIGH;
  localparam logic [7:0] a_cntl = `CCT_OFS_COUNTER_LOW;
  localparam logic [7:0] a_alth = `CCT_OFS_ALT_HIGH;
  localparam logic [7:0] a_altl = `CCT_OFS_ALT_LOW;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       por = 1'b1;
  logic       stop_mode = 1'b1;
  logic       cap_pin = 1'b0;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       wr_en;
  logic       rd_en;
  logic       cmp_pin;
  logic       irq;
  int         failures = 0;
  int         checks = 0;
  int         i;

  always #2 clk = ~clk;

  cct_timer #(.PRESCALE(4)) cct_timer_i (
    .clk                   (clk),
    .reset                 (reset),
    .por                   (por),
    .addr                  (addr),
    .wdata                 (wdata),
    .wr_en                 (wr_en),
    .rd_en                 (rd_en),
    .rdata_ff              (rdata),
    .stop_mode             (stop_mode),
    .capture_input_pin     (cap_pin),
    .compare_output_pin_ff (cmp_pin),
    .timer_irq_ff          (irq)
  );

  cct_cpu_model cct_cpu_model_i (
    .clk      (clk),
    .rdata_ff (rdata),
    .addr     (addr),
    .wdata    (wdata),
    .wr_en    (wr_en),
    .rd_en    (rd_en)
  );

  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] s,
                     input logic [7:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    logic [7:0] d;
    cct_cpu_model_i.rd(a, d);
    chk($sformatf("reg %h", a), d & m, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cct_cpu_model_i.wr(a, d);
  endtask

  task automatic pulse_rst;
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    por <= 1'b0;
    rc(a_ctl, 8'he3, 8'h00);
    wr(a_ctl, 8'he3);
    rc(a_ctl, 8'he3, 8'he3);
    pulse_rst;
    rc(a_ctl, 8'he3, 8'h02);
    wr(a_ctl, 8'h22);
    wr(a_cnth, 8'h55);
    wr(a_altl, 8'h55);
    rc(a_cnth, 8'hff, 8'hff);
    rc(a_alth, 8'hff, 8'hff);
    // Lows must stay latched while the counter wraps underneath
    @(posedge clk);
    stop_mode <= 1'b0;
    repeat (6) @(posedge clk);
    rc(a_sts, 8'hff, 8'h00);
    repeat (20) @(posedge clk);
    rc(a_altl, 8'hff, 8'hfc);
    rc(a_cntl, 8'hff, 8'hfc);
    rc(a_sts, 8'hff, 8'h60);
    chk("irq", {7'h00, irq}, 8'h01);
    @(posedge clk);
    stop_mode <= 1'b1;
    pulse_rst;
    rc(a_sts, 8'hff, 8'h60);
    rc(a_altl, 8'hff, 8'hfc);
    rc(a_sts, 8'hff, 8'h60);
    rc(a_cntl, 8'hff, 8'hfc);
    rc(a_sts, 8'hff, 8'h40);
    rc(a_cmpl, 8'hff, 8'hff);
    rc(a_sts, 8'hff, 8'h00);
    wr(a_ctl, 8'h82);
    @(posedge clk);
    cap_pin <= 1'b1;
    repeat (4) @(posedge clk);
    rc(a_sts, 8'hff, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    @(posedge clk);
    stop_mode <= 1'b0;
    repeat (3) @(posedge clk);
    rc(a_sts, 8'h80, 8'h80);
    chk("irq", {7'h00, irq}, 8'h01);
    rc(a_caph, 8'hff, 8'hff);
    rc(a_capl, 8'hff, 8'hfc);
    rc(a_sts, 8'h80, 8'h00);
    rc(a_caph, 8'hff, 8'hff);
    @(posedge clk);
    cap_pin <= 1'b0;
    repeat (2) @(posedge clk);
    cap_pin <= 1'b1;
    repeat (4) @(posedge clk);
    rc(a_sts, 8'h80, 8'h00);
    rc(a_capl, 8'hff, 8'hfc);
    @(posedge clk);
    cap_pin <= 1'b0;
    repeat (4) @(posedge clk);
    rc(a_sts, 8'h80, 8'h00);
    @(posedge clk);
    cap_pin <= 1'b1;
    repeat (4) @(posedge clk);
    rc(a_sts, 8'h80, 8'h80);
    wr(a_ctl, 8'h01);
    cct_cpu_model_i.cmp_set(8'h00, 8'h40);
    chk("pin", {7'h00, cmp_pin}, 8'h00);
    rc(a_sts, 8'h40, 8'h00);
    for (i = 0; i < 600 && cmp_pin !== 1'b1; i++) begin
      @(posedge clk);
    end
    if (i == 600) begin
      failures++;
      end_sim;
    end
    chk("pin", {7'h00, cmp_pin}, 8'h01);
    rc(a_sts, 8'h40, 8'h40);
    // Only the compare flag is enabled, so it alone drives the request
    wr(a_ctl, 8'h40);
    repeat (2) @(posedge clk);
    chk("irq", {7'h00, irq}, 8'h01);
    rc(a_cmpl, 8'hff, 8'h40);
    @(posedge clk);
    chk("irq", {7'h00, irq}, 8'h00);
    end_sim;
  end

  // Hang guard well above the longest wait
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim;
  end
endmodule
`default_nettype wire
